// ---- dv/interrupt_return_decode_tb.sv ----
// Purpose: self-checking bench for the interrupt-return decode block
// Assumes: no return executes during an apb transfer, so pready is prompt
// Notes: stack entries are pushed over apb before every pop
`timescale 1ns/10ps
`default_nettype none
`include "interrupt_return_op_map.svh"
module interrupt_return_decode_tb;
   logic clock, reset, instrValid, carryFlag, zeroFlag, signFlag, intAck;
   logic psel, penable, pwrite, pslverr, pready;
   logic interruptInService, flagsHold, returnTaken;
   interrupt_return_op_pkg::word_t instrWord, instructionPointer, ipOld;
   interrupt_return_op_pkg::sp_t stackPointer, spOld;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic err;
   int badCount, nTests;
   interrupt_return_op_pkg::word_t opTab [6];
   int flagSel [6];
   logic polTab [6];

   interrupt_return_decode dut (.clock(clock), .reset(reset),
      .instrValid(instrValid), .instrWord(instrWord),
      .carryFlag(carryFlag), .zeroFlag(zeroFlag), .signFlag(signFlag),
      .intAck(intAck), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .instructionPointer(instructionPointer),
      .stackPointer(stackPointer), .interruptInService(interruptInService),
      .flagsHold(flagsHold), .returnTaken(returnTaken));

   always #4 clock = ~clock;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         badCount++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // the request stays put until pready is seen high at an edge, or until 20 edges have passed
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk(pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic exec(input interrupt_return_op_pkg::word_t w, input logic c,
         input logic z, input logic s);
      @(posedge clock);
      instrValid <= 1'b1;
      instrWord <= w;
      carryFlag <= c;
      zeroFlag <= z;
      signFlag <= s;
      @(posedge clock);
      instrValid <= 1'b0;
      #1;
   endtask

   task automatic reset_values();
      chk(instructionPointer, `IP_RESET);
      chk(stackPointer, `SP_RESET);
      chk(interruptInService, 1'b0);
      apb(1'b0, `ADDR_CTRL, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, 12'h0f0, 32'h0);
      chk({rd, err}, {32'h0, 1'b1});
   endtask

   // every form, with its flag both ways; the other flags disagree
   task automatic all_forms();
      logic f, taken;
      logic [2:0] fl;
      interrupt_return_op_pkg::word_t val;
      for (int i = 0; i < 6; i++) begin
         for (int t = 0; t < 2; t++) begin
            val = 16'h1000 + 16'(i * 2 + t);
            apb(1'b1, `ADDR_PUSH, {16'h0, val});
            if (t == 1) apb(1'b1, `ADDR_CTRL, 32'h3);
            else begin
               @(posedge clock);
               intAck <= 1'b1;
               @(posedge clock);
               intAck <= 1'b0;
            end
            #1;
            ipOld = instructionPointer;
            spOld = stackPointer;
            chk(interruptInService, 1'b1);
            f = (t == 1) ? polTab[i] : ~polTab[i];
            fl = {3{~f}};
            fl[flagSel[i]] = f;
            taken = (i == 5) || (t == 1);
            exec(opTab[i], fl[0], fl[1], fl[2]);
            if (taken) begin
               chk(instructionPointer, val);
               chk(stackPointer, spOld - `SP_STEP);
               chk(interruptInService, 1'b0);
            end else begin
               chk(instructionPointer, ipOld + `IP_STEP);
               chk(stackPointer, spOld);
               chk(interruptInService, 1'b1);
            end
            chk(returnTaken, taken);
            chk(flagsHold, 1'b1);
         end
      end
   endtask

   task automatic refused_words();
      #1;
      ipOld = instructionPointer;
      spOld = stackPointer;
      exec(16'h8c0d, 1'b1, 1'b1, 1'b1);
      chk({instructionPointer, stackPointer}, {ipOld, spOld});
      chk({returnTaken, flagsHold}, 2'b00);
      apb(1'b1, `ADDR_CTRL, 32'h0);
      exec(`OPC_RETURN_ALWAYS, 1'b0, 1'b0, 1'b0);
      chk({instructionPointer, stackPointer}, {ipOld, spOld});
      apb(1'b1, `ADDR_CTRL, 32'h1);
   endtask

   // software view: pointer writes, readback and in-service status
   task automatic register_paths();
      apb(1'b1, `ADDR_IP, 32'h0000_1234);
      apb(1'b1, `ADDR_SP, 32'h0000_0003);
      #1;
      chk({instructionPointer, stackPointer}, {16'h1234, 4'h3});
      apb(1'b0, `ADDR_IP, 32'h0);
      chk(rd, 32'h0000_1234);
      apb(1'b0, `ADDR_SP, 32'h0);
      chk(rd, 32'h0000_0003);
      apb(1'b1, `ADDR_CTRL, 32'h3);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk(rd, 32'h0000_0001);
      exec(`OPC_RETURN_NZ, 1'b0, 1'b1, 1'b0);
      chk({instructionPointer, stackPointer}, {16'h1235, 4'h3});
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk(rd, 32'h0000_0001);
   endtask

   initial begin
      opTab = '{`OPC_RETURN_C, `OPC_RETURN_NC, `OPC_RETURN_Z,
         `OPC_RETURN_NZ, `OPC_RETURN_S, `OPC_RETURN_ALWAYS};
      flagSel = '{0, 0, 1, 1, 2, 0};
      polTab = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
      clock = 1'b0;
      reset = 1'b1;
      {instrValid, carryFlag, zeroFlag, signFlag, intAck} = 5'h00;
      {psel, penable, pwrite} = 3'h0;
      instrWord = 16'h0000;
      paddr = 12'h000;
      pwdata = 32'h0;
      badCount = 0;
      nTests = 0;
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      #1;
      reset_values();
      all_forms();
      refused_words();
      register_paths();
      giveVerdict();
   end

   // whole run needs well under two hundred cycles
   initial begin
      #100000;
      badCount++;
      giveVerdict();
   end
endmodule
`default_nettype wire

// ---- rtl/interrupt_return_decode.sv ----
// Purpose: execute return-from-interrupt and its flag-conditional forms
// Assumes: instruction word and flags come from core logic on this clock
// Notes: apb waits one cycle while a return executes, so stack and
//    pointers never see two writers in one cycle
`timescale 1ns/10ps
`default_nettype none
`include "interrupt_return_op_map.svh"
module interrupt_return_decode (
   input wire logic clock,
   input wire logic reset,
   input wire logic instrValid,
   input wire logic [15:0] instrWord,
   input wire logic carryFlag,
   input wire logic zeroFlag,
   input wire logic signFlag,
   input wire logic intAck,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [15:0] instructionPointer,
   output logic [3:0] stackPointer,
   output logic interruptInService,
   output logic flagsHold,
   output logic returnTaken
);
   localparam int STACK_DEPTH = 16;

   interrupt_return_op_if evalBus ();
   interrupt_return_op_pkg::word_t stackMem [STACK_DEPTH];
   interrupt_return_op_pkg::word_t ip_r;
   interrupt_return_op_pkg::word_t ip_nxt;
   interrupt_return_op_pkg::sp_t sp_r;
   interrupt_return_op_pkg::sp_t sp_nxt;
   interrupt_return_op_pkg::word_t topWord;
   logic inSvc_r;
   logic decodeEn_r;
   logic taken_r;
   logic skipped_r;
   logic flagsHold_r;
   logic [31:0] prdata_r;
   logic execNow;
   logic execTaken;
   logic execSkip;
   logic apbAccess;
   logic apbWrite;
   logic mapped;

   assign evalBus.opcode = instrWord;
   assign evalBus.carry = carryFlag;
   assign evalBus.zero = zeroFlag;
   assign evalBus.sign = signFlag;

   interrupt_return_op_cond_eval condEval (
      .bus(evalBus.eval)
   );

   assign execNow = instrValid && decodeEn_r && evalBus.isReturn;
   assign execTaken = execNow && evalBus.taken;
   assign execSkip = execNow && !evalBus.taken;
   assign topWord = stackMem[sp_r];

   function automatic logic isMapped(input logic [11:0] a);
      isMapped = (a == `ADDR_CTRL) || (a == `ADDR_IP) ||
         (a == `ADDR_SP) || (a == `ADDR_STATUS) || (a == `ADDR_PUSH);
   endfunction

   // bus waits during a return cycle instead of racing it
   assign pready = !execNow;
   assign mapped = isMapped(paddr);
   assign apbAccess = psel && penable && pready;
   assign apbWrite = apbAccess && pwrite && mapped;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_r;

   always_comb begin
      ip_nxt = ip_r;
      sp_nxt = sp_r;
      if (execTaken) begin
         ip_nxt = topWord;
         sp_nxt = sp_r - `SP_STEP;
      end else if (execSkip) begin
         ip_nxt = ip_r + `IP_STEP;
      end else if (apbWrite && paddr == `ADDR_IP) begin
         ip_nxt = pwdata[15:0];
      end else if (apbWrite && paddr == `ADDR_SP) begin
         sp_nxt = pwdata[3:0];
      end else if (apbWrite && paddr == `ADDR_PUSH) begin
         sp_nxt = sp_r + `SP_STEP;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ip_r <= `IP_RESET;
         sp_r <= `SP_RESET;
      end else begin
         ip_r <= ip_nxt;
         sp_r <= sp_nxt;
      end
   end

   // stack array carries no reset; contents are software-defined
   always_ff @(posedge clock) begin
      if (apbWrite && paddr == `ADDR_PUSH && !execNow) begin
         stackMem[sp_r + `SP_STEP] <= pwdata[15:0];
      end
   end

   // an acknowledge in the same cycle as a return wins
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         inSvc_r <= 1'b0;
      end else if (intAck) begin
         inSvc_r <= 1'b1;
      end else if (apbWrite && paddr == `ADDR_CTRL &&
            pwdata[`CTRL_SET_SERVICE]) begin
         inSvc_r <= 1'b1;
      end else if (execTaken) begin
         inSvc_r <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         decodeEn_r <= `CTRL_RESET;
      end else if (apbWrite && paddr == `ADDR_CTRL) begin
         decodeEn_r <= pwdata[`CTRL_DECODE_EN];
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         taken_r <= 1'b0;
         skipped_r <= 1'b0;
         flagsHold_r <= 1'b0;
      end else begin
         taken_r <= execTaken;
         skipped_r <= execSkip;
         // flags frozen for any return form
         flagsHold_r <= execNow;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (paddr)
            `ADDR_CTRL: prdata_r <= {31'h0000_0000, decodeEn_r};
            `ADDR_IP: prdata_r <= {16'h0000, ip_r};
            `ADDR_SP: prdata_r <= {28'h000_0000, sp_r};
            `ADDR_STATUS: prdata_r <= {29'h0000_0000, skipped_r, taken_r,
               inSvc_r};
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   assign instructionPointer = ip_r;
   assign stackPointer = sp_r;
   assign interruptInService = inSvc_r;
   assign flagsHold = flagsHold_r;
   assign returnTaken = taken_r;

   // condition checks decode from the raw word, not from the evaluator's outputs
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   chk_pop_pointer: assert property (
      execTaken |=> (ip_r == $past(topWord)) &&
         (sp_r == $past(sp_r) - `SP_STEP))
      else $error("taken return did not pop stack");
   chk_service_clear: assert property (
      execTaken && !intAck |=> !inSvc_r)
      else $error("in-service not cleared by return");
   chk_ack_sets: assert property (
      intAck |=> inSvc_r)
      else $error("acknowledge did not set in-service");
   chk_carry_cond: assert property (
      instrValid && decodeEn_r && instrWord == `OPC_RETURN_C
         |-> execTaken == carryFlag)
      else $error("carry variant condition wrong");
   chk_nocarry_cond: assert property (
      instrValid && decodeEn_r && instrWord == `OPC_RETURN_NC
         |-> execTaken == !carryFlag)
      else $error("no-carry variant condition wrong");
   chk_zero_cond: assert property (
      instrValid && decodeEn_r && instrWord == `OPC_RETURN_Z
         |-> execTaken == zeroFlag)
      else $error("zero variant condition wrong");
   chk_skip_advance: assert property (
      execSkip |=> (ip_r == $past(ip_r) + `IP_STEP) && $stable(sp_r)
         && (inSvc_r == ($past(inSvc_r) || $past(intAck))) && skipped_r)
      else $error("false condition must only advance pointer");
   chk_skip_no_pulse: assert property (
      execSkip |=> !returnTaken)
      else $error("skipped return flagged as taken");
   chk_always_taken: assert property (
      instrValid && decodeEn_r && instrWord == `OPC_RETURN_ALWAYS
         |-> execTaken ##1 taken_r)
      else $error("unconditional return not taken");
   chk_nonzero_cond: assert property (
      instrValid && decodeEn_r && instrWord == `OPC_RETURN_NZ
         |-> execTaken == !zeroFlag)
      else $error("nonzero variant condition wrong");
   chk_sign_cond: assert property (
      instrValid && decodeEn_r && instrWord == `OPC_RETURN_S
         |-> execTaken == signFlag)
      else $error("negative variant condition wrong");
   chk_flags_frozen: assert property (
      execNow |=> flagsHold)
      else $error("flags not held after return form");
   chk_bus_waits: assert property (
      instrValid && decodeEn_r && instrWord == `OPC_RETURN_Z && !zeroFlag
         |-> !pready ##1 $stable(sp_r))
      else $error("zero variant with zero clear must not pop");
endmodule
`default_nettype wire

// ---- rtl/interrupt_return_op_cond_eval.sv ----
// Purpose: classify a word as a return-from-interrupt form and test its flag
// Assumes: flags are the core's current carry, zero and sign
// Notes: combinational only
`timescale 1ns/10ps
`default_nettype none
`include "interrupt_return_op_map.svh"
module interrupt_return_op_cond_eval (
   interrupt_return_op_if.eval bus
);
   function automatic interrupt_return_op_pkg::cond_e classify(input interrupt_return_op_pkg::word_t op);
      case (op)
         `OPC_RETURN_ALWAYS: classify = interrupt_return_op_pkg::COND_ALWAYS;
         `OPC_RETURN_C: classify = interrupt_return_op_pkg::COND_C;
         `OPC_RETURN_NC: classify = interrupt_return_op_pkg::COND_NC;
         `OPC_RETURN_Z: classify = interrupt_return_op_pkg::COND_Z;
         `OPC_RETURN_NZ: classify = interrupt_return_op_pkg::COND_NZ;
         `OPC_RETURN_S: classify = interrupt_return_op_pkg::COND_S;
         default: classify = interrupt_return_op_pkg::COND_NONE;
      endcase
   endfunction

   always_comb begin
      bus.kind = classify(bus.opcode);
      bus.isReturn = (bus.kind != interrupt_return_op_pkg::COND_NONE);
      case (bus.kind)
         interrupt_return_op_pkg::COND_ALWAYS: bus.taken = 1'b1;
         interrupt_return_op_pkg::COND_C: bus.taken = bus.carry;
         interrupt_return_op_pkg::COND_NC: bus.taken = !bus.carry;
         interrupt_return_op_pkg::COND_Z: bus.taken = bus.zero;
         interrupt_return_op_pkg::COND_NZ: bus.taken = !bus.zero;
         interrupt_return_op_pkg::COND_S: bus.taken = bus.sign;
         default: bus.taken = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ---- shared/interrupt_return_op_if.sv ----
// Purpose: carries an opcode and flags to the condition evaluator and back
// Assumes: same clock on both sides, purely combinational path
// Notes: the evaluator holds no state
`timescale 1ns/10ps
`default_nettype none
interface interrupt_return_op_if;
   interrupt_return_op_pkg::word_t opcode;
   logic carry;
   logic zero;
   logic sign;
   logic isReturn;
   logic taken;
   interrupt_return_op_pkg::cond_e kind;
   modport eval (input opcode, input carry, input zero, input sign,
      output isReturn, output taken, output kind);
   modport core (output opcode, output carry, output zero, output sign,
      input isReturn, input taken, input kind);
endinterface
`default_nettype wire

// ---- shared/interrupt_return_op_map.svh ----
// Purpose: named constants for the interrupt-return decode block
// Assumes: 16-bit instruction words, 16-entry stack, APB with 32-bit data
// Notes: opcodes are full 16-bit patterns, compared exactly
`ifndef INTERRUPT_RETURN_OP_MAP_SVH
`define INTERRUPT_RETURN_OP_MAP_SVH

`define OPC_RETURN_ALWAYS 16'h8c8d
`define OPC_RETURN_C 16'hac8d
`define OPC_RETURN_NC 16'hec8d
`define OPC_RETURN_Z 16'h9c8d
`define OPC_RETURN_NZ 16'hdc8d
`define OPC_RETURN_S 16'hcc8d

`define IP_STEP 16'h0001
`define SP_STEP 4'h1
`define IP_RESET 16'h0000
`define SP_RESET 4'h0

`define ADDR_CTRL 12'h000
`define ADDR_IP 12'h004
`define ADDR_SP 12'h008
`define ADDR_STATUS 12'h00c
`define ADDR_PUSH 12'h010

`define CTRL_DECODE_EN 0
`define CTRL_SET_SERVICE 1
`define CTRL_RESET 1'b1
`define STAT_SERVICE 0
`define STAT_TAKEN 1
`define STAT_SKIPPED 2

`endif

// ---- shared/interrupt_return_op_pkg.sv ----
// Purpose: types shared by the interrupt-return decode block
// Assumes: nothing beyond the map header
// Notes: condition kinds are coded once here
`default_nettype none
package interrupt_return_op_pkg;
   typedef enum logic [2:0] {
      COND_NONE = 3'b000,
      COND_ALWAYS = 3'b001,
      COND_C = 3'b010,
      COND_NC = 3'b011,
      COND_Z = 3'b100,
      COND_NZ = 3'b101,
      COND_S = 3'b110
   } cond_e;
   typedef logic [15:0] word_t;
   typedef logic [3:0] sp_t;
endpackage
`default_nettype wire
